// File: hdl/tcc_defines.svh
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// ****************************************
// register byte addresses
// ****************************************
`define TCC_CTRL_ADDR 8'h00
`define TCC_CNT_HI_ADDR 8'h04
`define TCC_CNT_LO_ADDR 8'h08
`define TCC_STATUS_ADDR 8'h0C
`define TCC_PTR_ADDR 8'h10
`define TCC_CC_LO_ADDR 8'h14
`define TCC_CC_HI_ADDR 8'h18
`define TCC_RELOAD_ADDR 8'h1C
`define TCC_CMPCTL_ADDR 8'h20
`define TCC_SWTRIG_ADDR 8'h24
// ****************************************
// field positions
// ****************************************
`define TCC_CTRL_SRC_LSB 0
`define TCC_CTRL_WRMODE_BIT 3
`define TCC_CTRL_STOP_BIT 4
`define TCC_STAT_TMR_BIT 0
`define TCC_STAT_OUT_LSB 1
`define TCC_STAT_CMP_LSB 4
`define TCC_STAT_CAP_LSB 10
`define TCC_CMPCTL_TEN_LSB 0
`define TCC_CMPCTL_LVL_LSB 3
`define TCC_CMPCTL_SRC_LSB 6
`define TCC_PTR_CAP0 3'h6
`define TCC_PTR_CAP1 3'h7
// ****************************************
// reset values
// ****************************************
`define TCC_CNT_RST 16'hFFFF
`define TCC_CTRL_RST 5'h00
`endif

// File: hdl/tcc_pkg.sv
package tcc_pkg;
    // count source select, in register encoding order
    typedef enum logic [2:0] {
        TCC_SRC_DIV2,
        TCC_SRC_DIV16,
        TCC_SRC_DIV32,
        TCC_SRC_DIV64,
        TCC_SRC_DIV128,
        TCC_SRC_DIV256,
        TCC_SRC_LSO,
        TCC_SRC_SUB
    } tcc_src_t;
endpackage

// File: hdl/tcc_top.sv
// Operation
// - 16-bit timer counts sysclk/2,/16,/32,/64,/128,/256, slow osc or sub clock
// - decrement per pulse; pulse at zero underflows, reloads from latch, continues
// - every underflow sets the timer interrupt request bit
// - write mode picks latch and counter, or latch alone
// - counter and latch start from all ones after reset
// - timer divides its source by setting plus one
// - counting halts while the stop bit is one
// - latch-only mode updates only the latch, even when stopped
// - three independent compare channels share registers with capture
// - reload bit moves staged value into latch at underflow, then clears
// - count match triggers the waveform circuit, gated by trigger enable
// - level zero: first match drives high, second low; level one inverts
// - trigger disabled keeps pin fixed; matches and requests still occur
// - each compare latch match requests, gated by its source bit
// - stopped: compare write goes straight to latch; enable initialises output
// - compare value above timer setting never matches
// - rising trigger edge captures into latch 00, falling into latch 01
// - software trigger writes capture the count; trigger bits read zero
//
// Implementation choices: the address map and the APB interface to the registers.
`include "tcc_defines.svh"
module tcc_top #(
    parameter int NUM_CMP = 3
) (
    input wire logic pclk,                    // system clock
    input wire logic presetn,                 // async reset
    input wire logic psel,                    // apb select
    input wire logic penable,                 // apb enable
    input wire logic pwrite,                  // apb direction
    input wire logic [7:0] paddr,             // apb byte address
    input wire logic [31:0] pwdata,           // apb write data
    output logic [31:0] prdata,               // apb read data
    output logic pready,                      // apb ready
    output logic pslverr,                     // unmapped address
    input wire logic lso_clk_in,              // low-speed oscillator
    input wire logic sub_clock_input,         // sub clock pin
    input wire logic capture_in,              // capture trigger pin
    output logic [NUM_CMP-1:0] cmp_out        // compare waveforms
);
    import tcc_pkg::*;

    localparam int NL = 2 * NUM_CMP;

    // pointer is three bits, so at most three channel pairs
    initial begin
        if (NUM_CMP < 1 || NUM_CMP > 3) begin
            $error("NUM_CMP must be 1 to 3");
        end
    end

    // ****************************************
    // state
    // ****************************************
    logic [7:0] prescale, next_prescale;
    logic [2:0] lso_s, sub_s, cap_s;
    logic [2:0] src_sel, next_src_sel;
    logic wr_latch_only, next_wr_latch_only;
    logic stop, next_stop;
    logic [15:0] cnt, next_cnt;
    logic [15:0] tlatch, next_tlatch;
    logic [7:0] lo_wbuf, next_lo_wbuf;
    logic [7:0] rd_buf, next_rd_buf;
    logic cnt_moved, next_cnt_moved;
    logic tmr_req, next_tmr_req;
    logic [2:0] ptr, next_ptr;
    logic [15:0] cmp_stage [NL];
    logic [15:0] next_cmp_stage [NL];
    logic [15:0] cmp_latch [NL];
    logic [15:0] next_cmp_latch [NL];
    logic [NL-1:0] reload, next_reload;
    logic [NL-1:0] src_en, next_src_en;
    logic [NL-1:0] cmp_req, next_cmp_req;
    logic [NUM_CMP-1:0] trig_en, next_trig_en;
    logic [NUM_CMP-1:0] lvl, next_lvl;
    logic [NUM_CMP-1:0] next_cmp_out;
    logic [15:0] cap [2];
    logic [15:0] next_cap [2];
    logic [1:0] cap_flag, next_cap_flag;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    // ****************************************
    // decode and sources
    // ****************************************
    logic go, acc, wr, rd_go, hit, tick, uf;
    logic lso_rise, sub_rise, cap_rise, cap_fall;
    logic [NL-1:0] match;
    logic [15:0] sel16;
    logic [31:0] rd_val;

    // first access cycle answers, second completes
    assign go = psel & penable & ~pready;
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign rd_go = go & ~pwrite;

    // edges taken from the settled stages only
    assign lso_rise = lso_s[1] & ~lso_s[2];
    assign sub_rise = sub_s[1] & ~sub_s[2];
    assign cap_rise = cap_s[1] & ~cap_s[2];
    assign cap_fall = ~cap_s[1] & cap_s[2];

    // count pulse from the selected source
    always_comb begin
        case (tcc_src_t'(src_sel))
            TCC_SRC_DIV2: tick = prescale[0];
            TCC_SRC_DIV16: tick = &prescale[3:0];
            TCC_SRC_DIV32: tick = &prescale[4:0];
            TCC_SRC_DIV64: tick = &prescale[5:0];
            TCC_SRC_DIV128: tick = &prescale[6:0];
            TCC_SRC_DIV256: tick = &prescale[7:0];
            TCC_SRC_LSO: tick = lso_rise;
            TCC_SRC_SUB: tick = sub_rise;
            default: tick = 1'b0;
        endcase
    end

    assign uf = tick & ~stop & (cnt == 16'h0000) & ~(wr && paddr == `TCC_CNT_HI_ADDR);

    // match only on a fresh count value, so a stopped timer fires once
    for (genvar g = 0; g < NL; g++) begin : g_match
        assign match[g] = cnt_moved && (cnt == cmp_latch[g])
                          && (cmp_latch[g] <= tlatch);
    end

    // shared capture/compare window
    always_comb begin
        if (ptr == `TCC_PTR_CAP0 || ptr == `TCC_PTR_CAP1) begin
            sel16 = cap[ptr[0]];
        end else if (ptr < 3'(NL)) begin
            sel16 = cmp_latch[ptr];
        end else begin
            sel16 = 16'h0000;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `TCC_CTRL_ADDR: rd_val = {27'h0, stop, wr_latch_only, src_sel};
            `TCC_CNT_HI_ADDR: rd_val = {24'h0, cnt[15:8]};
            `TCC_CNT_LO_ADDR: rd_val = {24'h0, rd_buf};
            `TCC_STATUS_ADDR: rd_val = 32'({cap_flag, 6'(cmp_req), 3'(cmp_out), tmr_req});
            `TCC_PTR_ADDR: rd_val = {29'h0, ptr};
            `TCC_CC_HI_ADDR: rd_val = {24'h0, sel16[15:8]};
            `TCC_CC_LO_ADDR: rd_val = {24'h0, rd_buf};
            `TCC_RELOAD_ADDR: rd_val = 32'(reload);
            `TCC_CMPCTL_ADDR: rd_val = 32'({6'(src_en), 3'(lvl), 3'(trig_en)});
            `TCC_SWTRIG_ADDR: rd_val = 32'h0000_0000;
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // next values
    // ****************************************
    always_comb begin
        int i;
        i = 0;
        next_prescale = prescale + 8'h01;
        next_src_sel = src_sel;
        next_wr_latch_only = wr_latch_only;
        next_stop = stop;
        next_cnt = cnt;
        next_tlatch = tlatch;
        next_lo_wbuf = lo_wbuf;
        next_rd_buf = rd_buf;
        next_cnt_moved = 1'b0;
        next_tmr_req = tmr_req;
        next_ptr = ptr;
        next_cmp_stage = cmp_stage;
        next_cmp_latch = cmp_latch;
        next_reload = reload;
        next_src_en = src_en;
        next_cmp_req = cmp_req;
        next_trig_en = trig_en;
        next_lvl = lvl;
        next_cmp_out = cmp_out;
        next_cap = cap;
        next_cap_flag = cap_flag;
        next_pready = go;
        next_pslverr = go & ~hit;
        next_prdata = rd_go ? rd_val : prdata;

        // control and pointer writes
        if (wr && paddr == `TCC_CTRL_ADDR) begin
            next_src_sel = pwdata[`TCC_CTRL_SRC_LSB +: 3];
            next_wr_latch_only = pwdata[`TCC_CTRL_WRMODE_BIT];
            next_stop = pwdata[`TCC_CTRL_STOP_BIT];
        end
        if (wr && paddr == `TCC_PTR_ADDR) begin
            next_ptr = pwdata[2:0];
        end

        // low half waits for the high half
        if (wr && paddr == `TCC_CNT_LO_ADDR) begin
            next_lo_wbuf = pwdata[7:0];
        end
        // upper read freezes the lower byte for a coherent pair
        if (rd_go && paddr == `TCC_CNT_HI_ADDR) begin
            next_rd_buf = cnt[7:0];
        end
        if (rd_go && paddr == `TCC_CC_HI_ADDR) begin
            next_rd_buf = sel16[7:0];
        end

        // counter: a software load beats a count pulse
        if (wr && paddr == `TCC_CNT_HI_ADDR) begin
            next_tlatch = {pwdata[7:0], lo_wbuf};
            if (!wr_latch_only) begin
                next_cnt = {pwdata[7:0], lo_wbuf};
                next_cnt_moved = 1'b1;
            end
        end else if (tick && !stop) begin
            next_cnt_moved = 1'b1;
            if (cnt == 16'h0000) begin
                next_cnt = tlatch;
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end

        // timer request: set beats the write-one clear
        if (wr && paddr == `TCC_STATUS_ADDR && pwdata[`TCC_STAT_TMR_BIT]) begin
            next_tmr_req = 1'b0;
        end
        if (uf) begin
            next_tmr_req = 1'b1;
        end

        // compare latches
        for (i = 0; i < NL; i++) begin
            if (wr && paddr == `TCC_CC_LO_ADDR && ptr == 3'(i)) begin
                next_cmp_stage[i][7:0] = pwdata[7:0];
            end
            if (wr && paddr == `TCC_CC_HI_ADDR && ptr == 3'(i)) begin
                next_cmp_stage[i][15:8] = pwdata[7:0];
            end
            if (stop) begin
                next_cmp_latch[i] = next_cmp_stage[i];
            end
            if (uf && reload[i]) begin
                next_cmp_latch[i] = cmp_stage[i];
                next_reload[i] = 1'b0;
            end
            // a fresh request to reload wins over the automatic clear
            if (wr && paddr == `TCC_RELOAD_ADDR && pwdata[i]) begin
                next_reload[i] = 1'b1;
            end
            if (wr && paddr == `TCC_STATUS_ADDR && pwdata[`TCC_STAT_CMP_LSB + i]) begin
                next_cmp_req[i] = 1'b0;
            end
            if (match[i] && src_en[i]) begin
                next_cmp_req[i] = 1'b1;
            end
        end

        // compare control and waveform outputs
        if (wr && paddr == `TCC_CMPCTL_ADDR) begin
            next_trig_en = pwdata[`TCC_CMPCTL_TEN_LSB +: NUM_CMP];
            next_lvl = pwdata[`TCC_CMPCTL_LVL_LSB +: NUM_CMP];
            next_src_en = pwdata[`TCC_CMPCTL_SRC_LSB +: NL];
        end
        for (i = 0; i < NUM_CMP; i++) begin
            if (trig_en[i]) begin
                if (match[2 * i]) begin
                    next_cmp_out[i] = ~lvl[i];
                end else if (match[2 * i + 1]) begin
                    next_cmp_out[i] = lvl[i];
                end
            end
            // enabling while stopped parks the pin at its idle level
            if (stop && !trig_en[i] && next_trig_en[i]) begin
                next_cmp_out[i] = next_lvl[i];
            end
        end

        // capture from pin edges or software trigger
        if (wr && paddr == `TCC_STATUS_ADDR) begin
            next_cap_flag = cap_flag & ~pwdata[`TCC_STAT_CAP_LSB +: 2];
        end
        if (cap_rise || (wr && paddr == `TCC_SWTRIG_ADDR && pwdata[0])) begin
            next_cap[0] = cnt;
            next_cap_flag[0] = 1'b1;
        end
        if (cap_fall || (wr && paddr == `TCC_SWTRIG_ADDR && pwdata[1])) begin
            next_cap[1] = cnt;
            next_cap_flag[1] = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // pin synchronisers, stage 0 feeds stage 1 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lso_s <= 3'h0;
            sub_s <= 3'h0;
            cap_s <= 3'h0;
        end else begin
            lso_s <= {lso_s[1:0], lso_clk_in};
            sub_s <= {sub_s[1:0], sub_clock_input};
            cap_s <= {cap_s[1:0], capture_in};
        end
    end

    // block state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 8'h00;
            {stop, wr_latch_only, src_sel} <= `TCC_CTRL_RST;
            cnt <= `TCC_CNT_RST;
            tlatch <= `TCC_CNT_RST;
            lo_wbuf <= 8'h00;
            rd_buf <= 8'h00;
            cnt_moved <= 1'b0;
            tmr_req <= 1'b0;
            ptr <= 3'h0;
            for (int k = 0; k < NL; k++) begin
                cmp_stage[k] <= 16'h0000;
                cmp_latch[k] <= 16'h0000;
            end
            reload <= '0;
            src_en <= '0;
            cmp_req <= '0;
            trig_en <= '0;
            lvl <= '0;
            cmp_out <= '0;
            cap[0] <= 16'h0000;
            cap[1] <= 16'h0000;
            cap_flag <= 2'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prescale <= next_prescale;
            src_sel <= next_src_sel;
            wr_latch_only <= next_wr_latch_only;
            stop <= next_stop;
            cnt <= next_cnt;
            tlatch <= next_tlatch;
            lo_wbuf <= next_lo_wbuf;
            rd_buf <= next_rd_buf;
            cnt_moved <= next_cnt_moved;
            tmr_req <= next_tmr_req;
            ptr <= next_ptr;
            cmp_stage <= next_cmp_stage;
            cmp_latch <= next_cmp_latch;
            reload <= next_reload;
            src_en <= next_src_en;
            cmp_req <= next_cmp_req;
            trig_en <= next_trig_en;
            lvl <= next_lvl;
            cmp_out <= next_cmp_out;
            cap <= next_cap;
            cap_flag <= next_cap_flag;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule

// File: verif/tcc_props.sv
`include "tcc_defines.svh"
// ****************************************
// port checks
// ****************************************
module tcc_props #(
    parameter int NUM_CMP = 3
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // byte address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // error flag
    input wire logic lso_clk_in, // slow osc
    input wire logic sub_clock_input, // sub clock
    input wire logic capture_in, // capture pin
    input wire logic [NUM_CMP-1:0] cmp_out // waveforms
);
    logic done_wr;
    logic stop_bit;
    logic next_stop_bit;
    logic [1:0] stop_age;
    logic [1:0] next_stop_age;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // stop shadow; any write restarts the age since a load may move the count
    assign done_wr = psel && penable && pready && pwrite;
    always_comb begin
        next_stop_bit = stop_bit;
        if (done_wr && paddr == `TCC_CTRL_ADDR) begin
            next_stop_bit = pwdata[`TCC_CTRL_STOP_BIT];
        end
        next_stop_age = (stop_age == 2'd3) ? stop_age : stop_age + 2'd1;
        if (done_wr || !stop_bit) begin
            next_stop_age = 2'd0;
        end
    end
    // shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_bit <= 1'b0;
            stop_age <= 2'd0;
        end else begin
            stop_bit <= next_stop_bit;
            stop_age <= next_stop_age;
        end
    end
    sequence s_waiting;
        psel && penable && !pready;
    endsequence
    chk_one_wait: assert property (s_waiting |=> pready)
        else $error("access not answered after one wait");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_map_error: assert property (pready && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > `TCC_SWTRIG_ADDR))
        else $error("error flag does not match address");
    chk_data_hold: assert property ($changed(prdata) |-> pready && (!pwrite || pslverr))
        else $error("read data moved outside a read");
    chk_swtrig_zero: assert property (
        pready && !pwrite && paddr == `TCC_SWTRIG_ADDR |-> prdata[1:0] == 2'b00)
        else $error("trigger bits read nonzero");
    chk_reset_quiet: assert property ($rose(presetn) |-> cmp_out == '0 && !pready)
        else $error("outputs not quiet after reset");
    chk_stop_holds: assert property (stop_age == 2'd3 |-> $stable(cmp_out))
        else $error("waveform moved while stopped");
endmodule
bind tcc_top tcc_props #(.NUM_CMP(NUM_CMP)) i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lso_clk_in(lso_clk_in),
    .sub_clock_input(sub_clock_input), .capture_in(capture_in), .cmp_out(cmp_out));

// File: verif/tcc_pins.sv
// ****************************************
// pin-side model
// ****************************************
module tcc_pins (
    input wire logic pclk, // system clock
    input wire logic [2:0] cmp_out, // waveforms seen
    output logic lso_clk_in, // slow oscillator
    output logic sub_clock_input, // sub clock
    output logic capture_in // capture trigger
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] div = 6'h00;
    logic [2:0] last = 3'h0;
    int edges [3] = '{0, 0, 0};
    initial begin
        lso_clk_in = 1'b0;
        sub_clock_input = 1'b0;
        capture_in = 1'b0;
    end
    // slow clocks free running; waveform edges counted per channel
    always @(posedge pclk) begin
        div <= div + 6'h01;
        lso_clk_in <= div[2];
        sub_clock_input <= div[5];
        last <= cmp_out;
        for (int i = 0; i < 3; i++) begin
            if (cmp_out[i] !== last[i]) edges[i] <= edges[i] + 1;
        end
    end
    // level held long enough for the input synchroniser
    task automatic set_capture(input logic lvl);
        @(posedge pclk);
        capture_in <= lvl;
        repeat (6) @(posedge pclk);
    endtask
endmodule

// File: verif/timer16_capture_compare_bench.sv
`include "tcc_defines.svh"
// ****************************************
// timer block bench
// ****************************************
module timer16_capture_compare_bench import tcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic lso_clk_in, sub_clock_input, capture_in;
    logic [2:0] cmp_out;
    int errors, comparisons;
    tcc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lso_clk_in(lso_clk_in), .sub_clock_input(sub_clock_input),
        .capture_in(capture_in), .cmp_out(cmp_out));
    tcc_pins i_pins (.pclk(pclk), .cmp_out(cmp_out), .lso_clk_in(lso_clk_in),
        .sub_clock_input(sub_clock_input), .capture_in(capture_in));
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ok(input logic c);
        check(32'(c), 32'h1);
    endtask
    // one apb transfer; request held until ready is sampled
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // ready is judged at the rising edge, where the slave sees the same values
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pair_wr(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
        bus(1'b1, lo, 32'(v[7:0]));
        bus(1'b1, hi, 32'(v[15:8]));
    endtask
    task automatic pair_rd(input logic [7:0] hi, input logic [7:0] lo, output logic [15:0] v);
        logic [7:0] h;
        bus(1'b0, hi, 32'h0);
        h = rd[7:0];
        bus(1'b0, lo, 32'h0);
        v = {h, rd[7:0]};
    endtask
    task automatic cnt_wr(input logic [15:0] v);
        pair_wr(`TCC_CNT_LO_ADDR, `TCC_CNT_HI_ADDR, v);
    endtask
    task automatic cnt_rd(output logic [15:0] v);
        pair_rd(`TCC_CNT_HI_ADDR, `TCC_CNT_LO_ADDR, v);
    endtask
    task automatic cc_wr(input logic [2:0] p, input logic [15:0] v);
        bus(1'b1, `TCC_PTR_ADDR, 32'(p));
        pair_wr(`TCC_CC_LO_ADDR, `TCC_CC_HI_ADDR, v);
    endtask
    task automatic cc_rd(input logic [2:0] p, output logic [15:0] v);
        bus(1'b1, `TCC_PTR_ADDR, 32'(p));
        pair_rd(`TCC_CC_HI_ADDR, `TCC_CC_LO_ADDR, v);
    endtask
    task automatic ctrl(input tcc_src_t s, input logic latch_only, input logic stop);
        bus(1'b1, `TCC_CTRL_ADDR, {27'h0, stop, latch_only, s});
    endtask
    task automatic t_reset();
        logic [15:0] v;
        ctrl(TCC_SRC_DIV2, 1'b0, 1'b1);
        bus(1'b0, `TCC_CTRL_ADDR, 32'h0);
        check(32'(rd[4:0]), 32'h10);
        cnt_rd(v);
        check(32'(v[15:8]), 32'hFF);
    endtask
    task automatic t_write();
        logic [15:0] v;
        cnt_wr(16'h1234);
        cnt_rd(v);
        check(32'(v), 32'h1234);
        ctrl(TCC_SRC_DIV2, 1'b1, 1'b1);
        cnt_wr(16'h5678);
        cnt_rd(v);
        check(32'(v), 32'h1234);
    endtask
    task automatic t_under();
        logic [15:0] v;
        int n;
        ctrl(TCC_SRC_DIV2, 1'b0, 1'b1);
        cnt_wr(16'h0003);
        bus(1'b1, `TCC_STATUS_ADDR, 32'hFFF);
        ctrl(TCC_SRC_DIV2, 1'b0, 1'b0);
        n = 0;
        do begin
            bus(1'b0, `TCC_STATUS_ADDR, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 10);
        check(32'(rd[0]), 32'h1);
        ctrl(TCC_SRC_DIV2, 1'b0, 1'b1);
        cnt_rd(v);
        ok(v <= 16'h0003);
    endtask
    task automatic t_rate();
        logic [15:0] v;
        int d, div;
        for (int s = 0; s < 8; s++) begin
            ctrl(tcc_src_t'(s), 1'b0, 1'b1);
            cnt_wr(16'h0200);
            ctrl(tcc_src_t'(s), 1'b0, 1'b0);
            repeat (600) @(posedge pclk);
            ctrl(tcc_src_t'(s), 1'b0, 1'b1); // timer stopped before access, so the count holds while it is read
            cnt_rd(v);
            d = 512 - int'(v);
            div = (s == 0) ? 2 : (8 << s);
            ok(s > 5 ? d > 0 : d >= 600 / div - 1 && d <= 612 / div + 1);
        end
    endtask
    task automatic t_cmp();
        logic [15:0] cv [6] = '{16'h8, 16'h4, 16'h6, 16'h7, 16'h14, 16'h15};
        logic [15:0] v;
        int e1, e2, n;
        ctrl(TCC_SRC_DIV2, 1'b0, 1'b1);
        for (int p = 0; p < 6; p++) cc_wr(3'(p), cv[p]);
        for (int l = 0; l < 2; l++) begin
            ctrl(TCC_SRC_DIV2, 1'b0, 1'b1);
            cnt_wr(16'h000F);
            bus(1'b1, `TCC_CMPCTL_ADDR, {20'h0, 6'h3F, 2'b00, 1'(l), 3'b000});
            bus(1'b1, `TCC_CMPCTL_ADDR, {20'h0, 6'h3F, 2'b00, 1'(l), 3'b101});
            repeat (2) @(negedge pclk);
            check(32'(cmp_out[0]), 32'(l));
            e1 = i_pins.edges[1];
            e2 = i_pins.edges[2];
            bus(1'b1, `TCC_STATUS_ADDR, 32'hFFF);
            ctrl(TCC_SRC_DIV2, 1'b0, 1'b0);
            for (n = 0; cmp_out[0] === 1'(l) && n < 200; n++) @(negedge pclk);
            cnt_rd(v);
            ok(v > 16'h4 && v < 16'h8);
            for (n = 0; cmp_out[0] !== 1'(l) && n < 200; n++) @(negedge pclk);
            check(32'(cmp_out[0]), 32'(l));
            bus(1'b0, `TCC_STATUS_ADDR, 32'h0);
            check(32'(rd[9:4]), 32'h0F);
            check(32'(i_pins.edges[1] - e1), 32'h0);
            check(32'(i_pins.edges[2] - e2), 32'h0);
        end
        cc_wr(3'h0, 16'h9);
        cc_rd(3'h0, v);
        check(32'(v), 32'h8);
        bus(1'b1, `TCC_RELOAD_ADDR, 32'h1);
        n = 0;
        do begin
            bus(1'b0, `TCC_RELOAD_ADDR, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        cc_rd(3'h0, v);
        check(32'(v), 32'h9);
    endtask
    task automatic t_cap();
        logic [15:0] v;
        ctrl(TCC_SRC_DIV2, 1'b0, 1'b1);
        cnt_wr(16'h1234);
        i_pins.set_capture(1'b1);
        cnt_wr(16'h2345);
        i_pins.set_capture(1'b0);
        cc_rd(`TCC_PTR_CAP0, v);
        check(32'(v), 32'h1234);
        cc_rd(`TCC_PTR_CAP1, v);
        check(32'(v), 32'h2345);
        cnt_wr(16'h0777);
        bus(1'b1, `TCC_SWTRIG_ADDR, 32'h2);
        cc_rd(`TCC_PTR_CAP1, v);
        check(32'(v), 32'h0777);
        bus(1'b0, `TCC_SWTRIG_ADDR, 32'h0);
        check(32'(rd[1:0]), 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        check({rd[30:0], err_seen}, 32'h1);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // reset, then the scenarios in turn
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        comparisons = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_write();
        t_under();
        t_rate();
        t_cmp();
        t_cap();
        end_of_test();
    end
endmodule
